// ### wos_pkg.sv
// constants shared by the write-only serial slave front end
package wos_pkg;
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [4:0] ADDR_PREFIX = 5'h19;
   localparam logic RW_WRITE = 1'h0;
   localparam logic [1:0] STRAP_GND = 2'h0;
   localparam logic [1:0] STRAP_SCL = 2'h1;
   localparam logic [1:0] STRAP_SDA = 2'h2;
   localparam logic [1:0] STRAP_VCC = 2'h3;
   localparam logic [1:0] STRAP_RST = 2'h0;
   localparam logic [1:0] STEP_IDLE = 2'h0;
   localparam logic [1:0] STEP_HIGH = 2'h1;
   localparam logic [1:0] STEP_LOW = 2'h2;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam int CLK_KHZ = 20000;
   localparam int SCL_MAX_KHZ = 400;
   localparam int SCL_MIN_HALF_CYC = CLK_KHZ / (2 * SCL_MAX_KHZ);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK, ST_DATA, ST_DACK, ST_HOLD
   } wos_state_t;
endpackage

// ### wos_strap.sv
// address strap decoder: finds what the strap pin is tied to
`timescale 1ns/10ps
`default_nettype none
module wos_strap (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   // synchronised bus view
   input wire logic ad_s,
   input wire logic bus_start,
   input wire logic scl_rise,
   input wire logic scl_fall,
   // decoded address bits two and one
   output logic [1:0] strap
);
   import wos_pkg::*;

   logic [1:0] step;
   logic at_start;
   logic at_high;
   logic [1:0] next_strap;

   // at start scl=1 sda=0; at first rise sda=1; after first fall scl=0
   assign next_strap = (!at_start && !at_high) ? STRAP_GND :
                       (!at_start && at_high) ? STRAP_SDA :
                       (at_start && at_high && !ad_s) ? STRAP_SCL :
                       (at_start && at_high) ? STRAP_VCC : STRAP_GND;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         step <= STEP_IDLE;
         at_start <= 1'b0;
         at_high <= 1'b0;
         strap <= STRAP_RST;
      end else if (ce) begin
         if (bus_start) begin
            step <= STEP_HIGH;
            at_start <= ad_s;
         end else if (step == STEP_HIGH && scl_rise) begin
            step <= STEP_LOW;
            at_high <= ad_s;
         end else if (step == STEP_LOW && scl_fall) begin
            step <= STEP_IDLE;
            strap <= next_strap;
         end
      end
   end

   strap_sda_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      step == STEP_LOW && scl_fall && !at_start && at_high |=> strap == STRAP_SDA)
      else $error("strap tied to data line not decoded as 10");
   strap_gnd_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      step == STEP_LOW && scl_fall && !at_start && !at_high |=> strap == STRAP_GND)
      else $error("strap tied to ground not decoded as 00");
endmodule
`default_nettype wire

// ### wos_slave.sv
// write-only two-wire serial slave front end
`timescale 1ns/10ps
`default_nettype none
module wos_slave (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   // two-wire bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // address strap pin
   input wire logic ad_i,
   // register bank write port
   output logic wr_stb,
   output logic [wos_pkg::BYTE_W-1:0] wr_addr,
   output logic [wos_pkg::BYTE_W-1:0] wr_data
);
   import wos_pkg::*;

   logic scl_m, scl_q, scl_d;
   logic sda_m, sda_q, sda_d;
   logic ad_m, ad_q;
   wos_state_t state, next_state;
   logic [2:0] cnt;
   logic byte_done;
   logic [BYTE_W-1:0] shreg;
   logic [BYTE_W-1:0] reg_addr;
   logic [1:0] strap;
   logic next_oe_n;
   logic next_stb;

   wire scl_rise = scl_q && !scl_d;
   wire scl_fall = !scl_q && scl_d;
   wire bus_start = scl_q && scl_d && sda_d && !sda_q;
   wire bus_stop = scl_q && scl_d && !sda_d && sda_q;
   wire in_byte = state == ST_ADDR || state == ST_REG || state == ST_DATA;
   wire byte_fall = in_byte && byte_done && scl_fall;
   wire in_ack = state == ST_AACK || state == ST_RACK || state == ST_DACK;
   wire addr_match = shreg[7:3] == ADDR_PREFIX && shreg[2:1] == strap
                     && shreg[0] == RW_WRITE;

   wos_strap wos_strap_inst (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .ad_s(ad_q),
      .bus_start(bus_start),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .strap(strap)
   );

   always_comb begin
      next_state = state;
      next_oe_n = sda_oe_n;
      next_stb = 1'b0;
      if (bus_start) begin
         next_state = ST_ADDR;
         next_oe_n = 1'b1;
      end else if (bus_stop) begin
         next_state = ST_IDLE;
         next_oe_n = 1'b1;
      end else if (byte_fall) begin
         case (state)
            ST_ADDR: begin
               next_state = addr_match ? ST_AACK : ST_HOLD;
               next_oe_n = !addr_match;
            end
            ST_REG: begin
               next_state = ST_RACK;
               next_oe_n = 1'b0;
            end
            ST_DATA: begin
               next_state = ST_DACK;
               next_oe_n = 1'b0;
               next_stb = 1'b1;
            end
            default: next_state = ST_HOLD;
         endcase
      end else if (in_ack && scl_fall) begin
         next_oe_n = 1'b1;
         case (state)
            ST_AACK: next_state = ST_REG;
            ST_RACK: next_state = ST_DATA;
            default: next_state = ST_HOLD;
         endcase
      end
   end

   // two-flop synchronisers give ample margin at 400kHz bus rates
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_m, scl_q, scl_d} <= 3'h7;
         {sda_m, sda_q, sda_d} <= 3'h7;
         {ad_m, ad_q} <= 2'h0;
      end else if (ce) begin
         {scl_m, scl_q, scl_d} <= {scl_i, scl_m, scl_q};
         {sda_m, sda_q, sda_d} <= {sda_i, sda_m, sda_q};
         {ad_m, ad_q} <= {ad_i, ad_m};
      end
   end

   // bit shifter, msb first
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= BIT_FIRST;
         byte_done <= 1'b0;
         shreg <= BYTE_RST;
      end else if (ce) begin
         if (bus_start || (in_ack && scl_fall)) begin
            cnt <= BIT_FIRST;
            byte_done <= 1'b0;
         end else if (in_byte && scl_rise && !byte_done) begin
            shreg <= {shreg[BYTE_W-2:0], sda_q};
            cnt <= cnt + 3'h1;
            byte_done <= cnt == BIT_LAST;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         sda_oe_n <= 1'b1;
         sda_o <= 1'b0;
         wr_stb <= 1'b0;
         reg_addr <= BYTE_RST;
         wr_addr <= BYTE_RST;
         wr_data <= BYTE_RST;
      end else if (ce) begin
         state <= next_state;
         sda_oe_n <= next_oe_n;
         sda_o <= 1'b0;
         wr_stb <= next_stb;
         if (byte_fall && state == ST_REG) begin
            reg_addr <= shreg;
         end
         if (next_stb) begin
            wr_addr <= reg_addr;
            wr_data <= shreg;
         end
      end
   end

   pull_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !sda_o)
      else $error("data line driven high");
   start_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      bus_start |=> state == ST_ADDR && cnt == BIT_FIRST && sda_oe_n)
      else $error("start not followed by address phase");
   stop_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      bus_stop && !bus_start |=> state == ST_IDLE && sda_oe_n)
      else $error("stop did not return to idle");
   addr_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      state == ST_ADDR && byte_fall && addr_match && !bus_start && !bus_stop
      |=> !sda_oe_n && state == ST_AACK)
      else $error("matching address not acknowledged");
   read_nack_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      state == ST_ADDR && byte_fall && shreg[0] && !bus_start && !bus_stop
      |=> sda_oe_n && state == ST_HOLD)
      else $error("read direction acknowledged");
   hold_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      state == ST_HOLD |-> sda_oe_n && !wr_stb)
      else $error("activity while ignoring transfer");
   bit_sample_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      in_byte && scl_rise && !byte_done && !bus_start && !bus_stop
      |=> shreg[0] == $past(sda_q) && $past(scl_q))
      else $error("bit not taken on high clock");
   ack_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      in_ack && scl_fall && !bus_start |=> sda_oe_n)
      else $error("acknowledge not released after ninth pulse");
   reg_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      state == ST_REG && byte_fall && !bus_start && !bus_stop
      |=> !sda_oe_n && reg_addr == $past(shreg))
      else $error("register address not captured and acknowledged");
   stb_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      wr_stb |-> !sda_oe_n && state == ST_DACK && wr_data == $past(shreg)
      ##1 !wr_stb)
      else $error("write strobe wrong or longer than one cycle");

   // data byte end: acknowledge, strobe and register address together
   data_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      state == ST_DATA && byte_fall && !bus_start && !bus_stop
      |=> !sda_oe_n && state == ST_DACK && wr_stb && wr_addr == $past(reg_addr))
      else $error("data byte not acknowledged with a write strobe");
   // only one data byte per transfer, later bytes are ignored
   after_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      state == ST_DACK && scl_fall && !bus_start && !bus_stop
      |=> state == ST_HOLD && sda_oe_n)
      else $error("bus not released after the data acknowledge");
   idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !ce)
      state == ST_IDLE |-> sda_oe_n && !wr_stb)
      else $error("activity while waiting for a start");

   addr_ack_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      state == ST_AACK && !sda_oe_n);
   write_c: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_stb);
   read_skip_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      state == ST_HOLD && scl_rise);
   restart_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      bus_start && state == ST_DATA);
   stop_hold_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      bus_stop && state == ST_HOLD);
endmodule
`default_nettype wire

// ### wos_master.sv
// two-wire bus master model facing the slave front end
`timescale 1ns/10ps
`default_nettype none
module wos_master #(
   parameter int PERIOD = 2600
) (
   // bus pins
   output logic scl,
   output logic sda_drv,
   input wire logic sda_w
);
   localparam int Q = PERIOD / 4;
   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end
   // start, also serves as a repeated start after an ack pulse
   task automatic start();
      #Q sda_drv = 1'h1;
      #Q scl = 1'h1;
      #Q sda_drv = 1'h0;
      #Q scl = 1'h0;
   endtask
   task automatic stop();
      #Q sda_drv = 1'h0;
      #Q scl = 1'h1;
      #Q sda_drv = 1'h1;
      #Q;
   endtask
   // data changes only while scl is low; period never under 2.5 us
   // a quarter period of whole ref_clk cycles keeps edges off the sampling edge
   task automatic send(input logic [7:0] b, output logic ack_n);
      for (int i = 7; i >= 0; i--) begin
         #Q sda_drv = b[i];
         #Q scl = 1'h1;
         #(2 * Q) scl = 1'h0;
      end
      #Q sda_drv = 1'h1;
      #Q scl = 1'h1;
      #Q ack_n = sda_w;
      #Q scl = 1'h0;
   endtask
endmodule
`default_nettype wire

// ### test_write_only_serial_slave_front_end.sv
// self-checking bench for the write-only serial slave front end
`timescale 1ns/10ps
`default_nettype none
module test_write_only_serial_slave_front_end;
   import wos_pkg::*;
   localparam int LIMIT = 60000;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic ce = 1'h1;
   logic [1:0] strap = STRAP_GND;
   logic scl, sda_drv, sda_o, sda_oe_n, wr_stb, k;
   logic [7:0] wr_addr, wr_data;
   logic [15:0] exp_q[$];
   wire sda_w = (sda_oe_n == 1'h0) ? sda_o : sda_drv;
   wire ad_i = (strap == STRAP_SCL) ? scl : (strap == STRAP_SDA) ? sda_w : strap[0];
   integer seed = 32'h2F15EC15;
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #25 ref_clk = ~ref_clk;
   wos_slave wos_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .ad_i(ad_i), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));
   wos_master wos_master_inst (.scl(scl), .sda_drv(sda_drv), .sda_w(sda_w));
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [7:0] rnd();
      return 8'($random(seed));
   endfunction
   // one write; ok says whether the address is ours, extra adds a byte
   task automatic xfer(input logic [7:0] a, input logic ok, input logic extra);
      logic [7:0] r, d;
      logic ack;
      @(negedge ref_clk);
      r = rnd();
      d = rnd();
      wos_master_inst.start();
      wos_master_inst.send(a, ack);
      check("addr_ack", {15'h0, ack}, {15'h0, ~ok});
      wos_master_inst.send(r, ack);
      check("reg_ack", {15'h0, ack}, {15'h0, ~ok});
      if (ok) exp_q.push_back({r, d});
      wos_master_inst.send(d, ack);
      check("data_ack", {15'h0, ack}, {15'h0, ~ok});
      if (extra) begin
         wos_master_inst.send(rnd(), ack);
         check("extra_ack", {15'h0, ack}, 16'h1);
      end
      wos_master_inst.stop();
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         tally_and_finish();
      end
      if (rst_n && sda_oe_n === 1'h0) check("sda_o", {15'h0, sda_o}, 16'h0);
      if (wr_stb === 1'h1) begin
         if (exp_q.size() == 0) check("stray_stb", 16'h1, 16'h0);
         else check("write", {wr_addr, wr_data}, exp_q.pop_front());
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge ref_clk);
      check("oe_idle", {15'h0, sda_oe_n}, 16'h1);
      for (int s = 0; s < 4; s++) begin
         @(posedge ref_clk) strap <= 2'(s);
         repeat (3) @(posedge ref_clk);
         xfer({ADDR_PREFIX, 2'(s), RW_WRITE}, 1'h1, s == 3);
         xfer({ADDR_PREFIX, 2'(s + 1), RW_WRITE}, 1'h0, 1'h0);
         xfer({ADDR_PREFIX, 2'(s), ~RW_WRITE}, 1'h0, 1'h0);
         xfer({5'h18, 2'(s), RW_WRITE}, 1'h0, 1'h0);
      end
      // repeated start after an acked register byte begins a fresh address
      wos_master_inst.start();
      wos_master_inst.send({ADDR_PREFIX, strap, RW_WRITE}, k);
      wos_master_inst.send(rnd(), k);
      check("pre_rs_ack", {15'h0, k}, 16'h0);
      xfer({ADDR_PREFIX, strap, RW_WRITE}, 1'h1, 1'h0);
      repeat (20) @(posedge ref_clk);
      check("unwritten", 16'(exp_q.size()), 16'h0);
      check("oe_end", {15'h0, sda_oe_n}, 16'h1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
